// ### src/perf_measure_channels.v
// Eight performance measurement channels watching prefetch and data accesses.
// Assumes fetch/access strobes come from logic on the same clock, one cycle each.
`timescale 1ns/10ps
`include "perf_measure_consts.vh"

module perf_measure_channels #(
  parameter AW = 32,
  parameter NCH = 8
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire [8:0]    regAddr,
  input  wire [31:0]   regWdata,
  input  wire          regWrite,
  input  wire          regRead,
  output reg  [31:0]   regRdata,
  input  wire          runStart,
  input  wire          fetchValid,
  input  wire [AW-1:0] fetchAddr,
  input  wire          accessValid,
  input  wire [AW-1:0] accessAddr,
  output reg           userBreak,
  output reg           traceHalt
);

  // ==========================================
  // Configuration storage
  reg  [2:0]    modeReg    [0:NCH-1];
  reg  [AW-1:0] startAReg  [0:NCH-1];
  reg  [AW-1:0] endAReg    [0:NCH-1];
  reg  [AW-1:0] startBReg  [0:NCH-1];
  reg  [AW-1:0] endBReg    [0:NCH-1];
  reg  [31:0]   ctrl_reg;
  reg  [39:0]   timeout_reg;
  reg  [31:0]   countUp_reg;
  reg  [1:0]    status_reg;
  // ==========================================
  // Measurement state
  reg  [31:0]   timeAcc    [0:NCH-1];
  reg  [31:0]   countAcc   [0:NCH-1];
  reg  [31:0]   maxTime    [0:NCH-1];
  reg  [31:0]   minTime    [0:NCH-1];
  reg  [39:0]   interval   [0:NCH-1];
  reg  [NCH-1:0] running_reg;
  reg  [NCH-1:0] prevA_reg;
  reg  [NCH-1:0] prevB_reg;
  reg  [8:0]    resid_reg;
  reg  [8:0]    resid_next;
  reg  [2:0]    ticks;
  reg  [8:0]    unitNs;
  reg  [NCH-1:0] goRun;
  reg  [NCH-1:0] goStop;
  reg  [NCH-1:0] incr;
  reg  [NCH-1:0] hitA;
  reg  [NCH-1:0] hitB;
  wire [8:0]    residSum;
  wire [39:0]   ivNow0;
  wire [31:0]   cntNext0;
  wire [1:0]    action;
  wire          tmoEvent;
  wire          cntEvent;
  integer       i;

  function inRange;
    input [AW-1:0] a;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    begin
      inRange = (a >= lo) && (a <= hi);
    end
  endfunction

  // ==========================================
  // Time base: fractional residue, since the clock period is no multiple of the 160 or 40 ns unit
  assign residSum = resid_reg + `CLK_PERIOD_NS;

  always @* begin
    case (ctrl_reg[`CTRL_UNIT_LSB+1:`CTRL_UNIT_LSB])
      `UNIT_40: unitNs = `UNIT_40_NS;
      `UNIT_20: unitNs = `UNIT_20_NS;
      default:  unitNs = `UNIT_160_NS;
    endcase
    ticks = 3'h0;
    resid_next = residSum;
    if (residSum >= unitNs) begin
      ticks = 3'h1;
      resid_next = residSum - unitNs;
    end
    if (resid_next >= unitNs) begin
      ticks = ticks + 3'h1;
      resid_next = resid_next - unitNs;
    end
    if (resid_next >= unitNs) begin
      ticks = ticks + 3'h1;
      resid_next = resid_next - unitNs;
    end
    if (unitNs == `UNIT_20_NS) begin
      ticks = 3'h5;
      resid_next = resid_reg;
    end
  end

  // ==========================================
  // Event decode per channel
  always @* begin
    goRun = {NCH{1'b0}};
    goStop = {NCH{1'b0}};
    incr = {NCH{1'b0}};
    hitA = {NCH{1'b0}};
    hitB = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      hitA[i] = fetchValid && inRange(fetchAddr, startAReg[i], endAReg[i]);
      hitB[i] = fetchValid && inRange(fetchAddr, startBReg[i], endBReg[i]);
      case (modeReg[i])
        `MODE_SINGLE: begin
          goRun[i] = hitA[i];
          goStop[i] = fetchValid && !hitA[i];
          incr[i] = fetchValid && (fetchAddr == endAReg[i]);
        end
        `MODE_P2P: begin
          // Only the two points matter, so called code keeps the clock running
          goRun[i] = fetchValid && (fetchAddr == startAReg[i]) && !running_reg[i];
          goStop[i] = fetchValid && (fetchAddr == endAReg[i]) && running_reg[i];
          incr[i] = fetchValid && (fetchAddr == endAReg[i]);
        end
        `MODE_R2R: begin
          goRun[i] = hitA[i] && !hitB[i] && !running_reg[i];
          goStop[i] = hitB[i] && running_reg[i];
          incr[i] = hitB[i] && !prevB_reg[i];
        end
        `MODE_ACCESS: begin
          incr[i] = accessValid && prevA_reg[i] &&
                    inRange(accessAddr, startBReg[i], endBReg[i]);
        end
        `MODE_CALL: begin
          incr[i] = hitB[i] && !prevB_reg[i] && prevA_reg[i];
        end
        default: incr[i] = 1'b0;
      endcase
    end
  end

  // ==========================================
  // Channel 0 checks timeout and count-up; no other channel raises either event
  assign ivNow0 = interval[0] + {37'h0, ticks};
  assign cntNext0 = countAcc[0] + 32'h1;
  assign action = ctrl_reg[`CTRL_ACT_LSB+1:`CTRL_ACT_LSB];
  assign tmoEvent = goStop[0] && (ivNow0 > timeout_reg);
  assign cntEvent = incr[0] && (cntNext0 > countUp_reg);

  // ==========================================
  // Measurement engine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resid_reg <= 9'h000;
      running_reg <= {NCH{1'b0}};
      prevA_reg <= {NCH{1'b0}};
      prevB_reg <= {NCH{1'b0}};
      userBreak <= 1'b0;
      traceHalt <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        timeAcc[i] <= 32'h0000_0000;
        countAcc[i] <= 32'h0000_0000;
        maxTime[i] <= 32'h0000_0000;
        minTime[i] <= `RST_MIN;
        interval[i] <= 40'h00_0000_0000;
      end
    end else if (runStart) begin
      resid_reg <= 9'h000;
      running_reg <= {NCH{1'b0}};
      prevA_reg <= {NCH{1'b0}};
      prevB_reg <= {NCH{1'b0}};
      userBreak <= 1'b0;
      traceHalt <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        timeAcc[i] <= 32'h0000_0000;
        countAcc[i] <= 32'h0000_0000;
        maxTime[i] <= 32'h0000_0000;
        minTime[i] <= `RST_MIN;
        interval[i] <= 40'h00_0000_0000;
      end
    end else begin
      resid_reg <= resid_next;
      userBreak <= (tmoEvent || cntEvent) && (action == `ACT_BREAK);
      if ((tmoEvent || cntEvent) && (action == `ACT_TRACE)) begin
        traceHalt <= 1'b1;
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (fetchValid) begin
          prevA_reg[i] <= hitA[i];
          prevB_reg[i] <= hitB[i];
        end
        if (running_reg[i]) begin
          timeAcc[i] <= timeAcc[i] + {29'h0, ticks};
          interval[i] <= interval[i] + {37'h0, ticks};
        end
        if (goRun[i]) begin
          running_reg[i] <= 1'b1;
          if (modeReg[i] != `MODE_SINGLE) begin
            interval[i] <= 40'h00_0000_0000;
          end
        end
        if (goStop[i]) begin
          running_reg[i] <= 1'b0;
          if ((modeReg[i] == `MODE_P2P) && (i < 4)) begin
            if ((interval[i][31:0] + {29'h0, ticks}) > maxTime[i]) begin
              maxTime[i] <= interval[i][31:0] + {29'h0, ticks};
            end
            if ((interval[i][31:0] + {29'h0, ticks}) < minTime[i]) begin
              minTime[i] <= interval[i][31:0] + {29'h0, ticks};
            end
          end
        end
        if (incr[i]) begin
          countAcc[i] <= countAcc[i] + 32'h1;
        end
      end
    end
  end

  // ==========================================
  // Register writes; mode pairing enforced here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `RST_CTRL;
      timeout_reg <= `RST_TMO;
      countUp_reg <= `RST_COUNTUP;
      status_reg <= 2'h0;
      for (i = 0; i < NCH; i = i + 1) begin
        modeReg[i] <= `MODE_OFF;
        startAReg[i] <= {AW{1'b0}};
        endAReg[i] <= {AW{1'b0}};
        startBReg[i] <= {AW{1'b0}};
        endBReg[i] <= {AW{1'b0}};
      end
    end else begin
      // Set wins over a same-cycle write-one clear
      if (action != `ACT_DISABLE) begin
        status_reg <= (status_reg & ~((regWrite && regAddr == `ADDR_STATUS) ?
                      regWdata[1:0] : 2'h0)) | {cntEvent, tmoEvent};
      end else if (regWrite && regAddr == `ADDR_STATUS) begin
        status_reg <= status_reg & ~regWdata[1:0];
      end
      if (regWrite) begin
        if (regAddr == `ADDR_CTRL) begin
          ctrl_reg <= regWdata;
        end else if (regAddr == `ADDR_TMO_LO) begin
          timeout_reg[31:0] <= regWdata;
        end else if (regAddr == `ADDR_TMO_HI) begin
          timeout_reg[39:32] <= regWdata[7:0];
        end else if (regAddr == `ADDR_COUNTUP) begin
          countUp_reg <= regWdata;
        end else if (!regAddr[8]) begin
          for (i = 0; i < NCH; i = i + 1) begin
            if (regAddr[7:5] == i) begin
              case (regAddr[4:2])
                `OFF_MODE: begin
                  if (regWdata[2:0] >= `MODE_R2R) begin
                    // Paired modes live only on the first channel of a pair
                    if (i % 2 == 0) begin
                      modeReg[i] <= regWdata[2:0];
                      modeReg[i+1] <= `MODE_OFF;
                    end
                  end else begin
                    modeReg[i] <= regWdata[2:0];
                    if ((i % 2 == 1) && (modeReg[i-1] >= `MODE_R2R)) begin
                      modeReg[i-1] <= `MODE_OFF;
                    end
                  end
                end
                `OFF_STARTA: startAReg[i] <= regWdata[AW-1:0];
                `OFF_ENDA:   endAReg[i] <= regWdata[AW-1:0];
                `OFF_STARTB: startBReg[i] <= regWdata[AW-1:0];
                `OFF_ENDB:   endBReg[i] <= regWdata[AW-1:0];
                default: ;
              endcase
            end
          end
        end
      end
    end
  end

  // ==========================================
  // Read port: data stands one cycle after the strobe, zero otherwise
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0000_0000;
    end else if (!regRead) begin
      regRdata <= 32'h0000_0000;
    end else if (regAddr == `ADDR_CTRL) begin
      regRdata <= ctrl_reg;
    end else if (regAddr == `ADDR_TMO_LO) begin
      regRdata <= timeout_reg[31:0];
    end else if (regAddr == `ADDR_TMO_HI) begin
      regRdata <= {24'h00_0000, timeout_reg[39:32]};
    end else if (regAddr == `ADDR_COUNTUP) begin
      regRdata <= countUp_reg;
    end else if (regAddr == `ADDR_STATUS) begin
      regRdata <= {30'h0, status_reg};
    end else if (regAddr[8:5] == `ADDR_MIN_BASE >> 5 && regAddr[1:0] == 2'h0) begin
      regRdata <= minTime[regAddr[4:2]];
    end else if (!regAddr[8] && regAddr[1:0] == 2'h0) begin
      case (regAddr[4:2])
        `OFF_MODE:   regRdata <= {29'h0, modeReg[regAddr[7:5]]};
        `OFF_STARTA: regRdata <= startAReg[regAddr[7:5]];
        `OFF_ENDA:   regRdata <= endAReg[regAddr[7:5]];
        `OFF_STARTB: regRdata <= startBReg[regAddr[7:5]];
        `OFF_ENDB:   regRdata <= endBReg[regAddr[7:5]];
        `OFF_TIME:   regRdata <= timeAcc[regAddr[7:5]];
        `OFF_COUNT:  regRdata <= countAcc[regAddr[7:5]];
        default:     regRdata <= maxTime[regAddr[7:5]];
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule

// ### src/perf_measure_consts.vh
// Constants for the performance measurement channels: map, fields, modes, timing.
// Assumes a plain byte-addressed register port with 32-bit data.
`ifndef PERF_MEASURE_CONSTS_VH
`define PERF_MEASURE_CONSTS_VH
// ==========================================
// Register map (byte addresses)
`define CH_STRIDE_SHIFT 5
`define OFF_MODE        3'h0
`define OFF_STARTA      3'h1
`define OFF_ENDA        3'h2
`define OFF_STARTB      3'h3
`define OFF_ENDB        3'h4
`define OFF_TIME        3'h5
`define OFF_COUNT       3'h6
`define OFF_MAX         3'h7
`define ADDR_CTRL       9'h100
`define ADDR_TMO_LO     9'h104
`define ADDR_TMO_HI     9'h108
`define ADDR_COUNTUP    9'h10C
`define ADDR_STATUS     9'h110
`define ADDR_MIN_BASE   9'h140
// ==========================================
// Fields
`define CTRL_UNIT_LSB   0
`define CTRL_ACT_LSB    2
`define STAT_TMO_BIT    0
`define STAT_CNT_BIT    1
// ==========================================
// Reset values
`define RST_CTRL        32'h0000_0000
`define RST_MIN         32'hFFFF_FFFF
`define RST_TMO         40'hFF_FFFF_FFFF
`define RST_COUNTUP     32'hFFFF_FFFF
// ==========================================
// Modes and actions
`define MODE_OFF        3'h0
`define MODE_SINGLE     3'h1
`define MODE_P2P        3'h2
`define MODE_R2R        3'h3
`define MODE_ACCESS     3'h4
`define MODE_CALL       3'h5
`define ACT_DISABLE     2'h0
`define ACT_BREAK       2'h1
`define ACT_TRACE       2'h2
`define UNIT_160        2'h0
`define UNIT_40         2'h1
`define UNIT_20         2'h2
// ==========================================
// Timing
`define CLK_PERIOD_NS   9'd100
`define UNIT_160_NS     9'd160
`define UNIT_40_NS      9'd40
`define UNIT_20_NS      9'd20
`endif

// ### verification/cpu_bus_model.sv
// Model of the processor's prefetch and data access strobes.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/10ps
module cpu_bus_model #(
  parameter AW = 32
) (
  input  wire          clk,
  output reg           fetchValid,
  output reg  [AW-1:0] fetchAddr,
  output reg           accessValid,
  output reg  [AW-1:0] accessAddr
);
  initial begin
    fetchValid  = 1'b0;
    fetchAddr   = {AW{1'b0}};
    accessValid = 1'b0;
    accessAddr  = {AW{1'b0}};
  end
  // ==========================================
  // One prefetch or access, taken at the next edge
  task fetch(input [AW-1:0] a);
    fetchValid <= 1'b1;
    fetchAddr  <= a;
    @(posedge clk);
  endtask
  task access(input [AW-1:0] a);
    accessValid <= 1'b1;
    accessAddr  <= a;
    @(posedge clk);
  endtask
  // Released lines show the inverse address so a stale value never matches
  task idle(input integer n);
    fetchValid  <= 1'b0;
    fetchAddr   <= ~fetchAddr;
    accessValid <= 1'b0;
    accessAddr  <= ~accessAddr;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ### verification/perf_measure_monitor.sv
// Checker for the measurement channels, bound to the top-level ports.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
module perf_measure_monitor (
  input wire clk,
  input wire reset_n,
  input wire runStart,
  input wire fetchValid,
  input wire accessValid,
  input wire userBreak,
  input wire traceHalt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Break and trace-stop actions
  AST_BREAK_ONE_CYCLE: assert property (userBreak |=> !userBreak)
    else $error("break pulse longer than one cycle");
  AST_BREAK_CAUSE: assert property (userBreak |-> $past(fetchValid || accessValid))
    else $error("break without a preceding event");
  AST_START_CLEARS: assert property ($past(runStart) |-> !userBreak && !traceHalt)
    else $error("action seen right after program start");
  AST_TRACE_HOLD: assert property (traceHalt && !runStart |=> traceHalt)
    else $error("trace stop dropped without program start");
  AST_TRACE_CAUSE: assert property ($rose(traceHalt) |-> $past(fetchValid || accessValid))
    else $error("trace stop without a preceding event");
  AST_ONE_ACTION: assert property ($rose(traceHalt) |-> !userBreak)
    else $error("break and trace stop raised together");
  AST_TRACE_FALL: assert property ($fell(traceHalt) |-> $past(runStart))
    else $error("trace stop cleared by something other than start");
  // Two idle cycles can end no interval, so no break may fire after them
  AST_IDLE_QUIET: assert property ((!fetchValid && !accessValid) [*2] |=> !userBreak)
    else $error("break after idle bus");
endmodule

bind perf_measure_channels perf_measure_monitor mon_u (.clk(clk), .reset_n(reset_n),
  .runStart(runStart), .fetchValid(fetchValid), .accessValid(accessValid),
  .userBreak(userBreak), .traceHalt(traceHalt));

// ### verification/testbench.sv
// Self-checking bench for the measurement channels over the register port.
// Assumes the 10 MHz clock and the map in the constants header.
`timescale 1ns/10ps
`include "perf_measure_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("unexpected %s: expected %h seen %h", nm, e, g); n_fail++; end end
module testbench;
  reg         clk;
  reg         reset_n;
  reg  [8:0]  regAddr;
  reg  [31:0] regWdata;
  reg         regWrite;
  reg         regRead;
  reg         runStart;
  wire [31:0] regRdata;
  wire        fetchValid;
  wire        accessValid;
  wire        userBreak;
  wire        traceHalt;
  wire [31:0] fetchAddr;
  wire [31:0] accessAddr;
  integer     n_fail = 0;
  integer     n_compared = 0;
  integer     nBreak = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (userBreak === 1'b1) nBreak <= nBreak + 1;
  perf_measure_channels dut_u (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .runStart(runStart),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .accessValid(accessValid),
    .accessAddr(accessAddr), .userBreak(userBreak), .traceHalt(traceHalt));
  cpu_bus_model cpu_u (.clk(clk), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .accessValid(accessValid), .accessAddr(accessAddr));
  // ==========================================
  // Register port tasks
  function [8:0] ra(input [2:0] ch, input [2:0] off);
    ra = {1'b0, ch, off, 2'b00};
  endfunction
  task wr(input [8:0] a, input [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rdc(input [8:0] a, input [31:0] e, input string nm);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHK(nm, e, regRdata)
  endtask
  task setch(input [2:0] ch, input [2:0] m, input [31:0] sa, ea, sb, eb);
    wr(ra(ch, `OFF_MODE), {29'h0, m});
    wr(ra(ch, `OFF_STARTA), sa);
    wr(ra(ch, `OFF_ENDA), ea);
    wr(ra(ch, `OFF_STARTB), sb);
    wr(ra(ch, `OFF_ENDB), eb);
  endtask
  task start;
    @(posedge clk);
    runStart <= 1'b1;
    @(posedge clk);
    runStart <= 1'b0;
  endtask
  // Start point, a called routine outside, then the end point: gap+2 cycles
  task interval(input integer gap);
    @(posedge clk);
    cpu_u.fetch(32'h100);
    cpu_u.fetch(32'h5000);
    cpu_u.idle(gap);
    cpu_u.fetch(32'h200);
    cpu_u.idle(2);
  endtask
  task unitrun(input [1:0] u, input integer gap, input [31:0] t);
    wr(`ADDR_CTRL, {30'h0, u});
    start;
    interval(gap);
    rdc(ra(0, `OFF_TIME), t, "time");
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict;
  end
  // ==========================================
  // Scenarios
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    regAddr = 9'h000;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    runStart = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rdc(`ADDR_CTRL, `RST_CTRL, "ctrl");
    rdc(`ADDR_TMO_LO, 32'hFFFF_FFFF, "tmoLo");
    rdc(`ADDR_TMO_HI, 32'h0000_00FF, "tmoHi");
    rdc(`ADDR_COUNTUP, `RST_COUNTUP, "countUp");
    rdc(9'h120, 32'h0, "hole");
    $display("test reset done");
    setch(0, `MODE_P2P, 32'h100, 32'h200, 32'h0, 32'h0);
    setch(4, `MODE_P2P, 32'h100, 32'h200, 32'h0, 32'h0);
    unitrun(`UNIT_20, 2, 32'd20);
    rdc(ra(0, `OFF_COUNT), 32'd1, "count");
    rdc(ra(0, `OFF_MAX), 32'd20, "max");
    rdc(`ADDR_MIN_BASE, 32'd20, "min");
    rdc(ra(4, `OFF_COUNT), 32'd1, "count4");
    rdc(ra(4, `OFF_MAX), 32'd0, "max4");
    unitrun(`UNIT_40, 2, 32'd10);
    unitrun(`UNIT_160, 6, 32'd5);
    $display("test point-to-point done");
    wr(`ADDR_CTRL, 32'h6);
    wr(`ADDR_TMO_LO, 32'd19);
    wr(`ADDR_TMO_HI, 32'h0);
    start;
    interval(2);
    `CHK("breaks", 1, nBreak)
    rdc(`ADDR_STATUS, 32'h1, "status");
    wr(`ADDR_TMO_LO, 32'd20);
    wr(`ADDR_STATUS, 32'h1);
    interval(2);
    `CHK("breaks", 1, nBreak)
    rdc(`ADDR_STATUS, 32'h0, "status");
    wr(`ADDR_COUNTUP, 32'd2);
    wr(`ADDR_CTRL, 32'hA);
    interval(2);
    `CHK("traceHalt", 1'b1, traceHalt)
    `CHK("breaks", 1, nBreak)
    rdc(`ADDR_STATUS, 32'h2, "status");
    start;
    @(negedge clk);
    `CHK("traceHalt", 1'b0, traceHalt)
    rdc(ra(0, `OFF_COUNT), 32'd0, "count");
    rdc(ra(0, `OFF_TIME), 32'd0, "time");
    rdc(`ADDR_MIN_BASE, 32'hFFFF_FFFF, "min");
    $display("test timeout done");
    setch(2, `MODE_R2R, 32'h300, 32'h30F, 32'h400, 32'h40F);
    start;
    cpu_u.fetch(32'h30F);
    cpu_u.fetch(32'h400);
    cpu_u.fetch(32'h40F);
    cpu_u.idle(1);
    rdc(ra(2, `OFF_COUNT), 32'd1, "count2");
    wr(ra(3, `OFF_MODE), {29'h0, `MODE_R2R});
    rdc(ra(3, `OFF_MODE), 32'h0, "mode3");
    wr(ra(3, `OFF_MODE), {29'h0, `MODE_SINGLE});
    rdc(ra(2, `OFF_MODE), 32'h0, "mode2");
    setch(2, `MODE_CALL, 32'h300, 32'h30F, 32'h400, 32'h40F);
    start;
    cpu_u.fetch(32'h305);
    cpu_u.fetch(32'h400);
    cpu_u.fetch(32'h401);
    cpu_u.fetch(32'h30F);
    cpu_u.fetch(32'h40F);
    cpu_u.idle(1);
    rdc(ra(2, `OFF_COUNT), 32'd2, "calls");
    setch(6, `MODE_ACCESS, 32'h600, 32'h6FF, 32'h8000, 32'h8003);
    start;
    cpu_u.fetch(32'h610);
    cpu_u.idle(1);
    cpu_u.access(32'h8003);
    cpu_u.access(32'h8004);
    cpu_u.access(32'h8000);
    cpu_u.idle(1);
    rdc(ra(6, `OFF_COUNT), 32'd2, "accesses");
    // Two in-range stretches of two cycles each, a pause outside between them
    setch(5, `MODE_SINGLE, 32'h700, 32'h70F, 32'h0, 32'h0);
    start;
    cpu_u.fetch(32'h700);
    cpu_u.fetch(32'h70F);
    cpu_u.fetch(32'h5000);
    cpu_u.idle(2);
    cpu_u.fetch(32'h705);
    cpu_u.fetch(32'h70F);
    cpu_u.fetch(32'h5000);
    cpu_u.idle(1);
    rdc(ra(5, `OFF_TIME), 32'd20, "time5");
    rdc(ra(5, `OFF_COUNT), 32'd2, "count5");
    $display("test paired modes done");
    give_verdict;
  end
endmodule
